// file: link_quality_monitor_ctrl.sv
`timescale 1ns/1ps
`include "lqm_cfg.svh"

module link_quality_monitor_ctrl (
  input  wire logic                         CLOCK,
  input  wire logic                         SRST,
  input  wire logic [`LQM_ADDR_W-1:0]       ADDR,
  input  wire logic [`LQM_DATA_W-1:0]       WDATA,
  input  wire logic                         WR,
  input  wire logic                         RD,
  output      logic [`LQM_DATA_W-1:0]       RDATA,
  input  wire logic                         LINK_100_OK,
  input  wire logic                         SIGNAL_DETECT_OPTION,
  input  wire logic                         INT_ENABLE,
  input  wire lqm_pkg::lq_vec_t             PARAM,
  input  wire lqm_pkg::lq_thr_t             THRESH,
  output      logic                         DSP_RESTART,
  output      logic                         LINK_DROP,
  output      logic                         IRQ_EVENT
);

  // --------------------------------------------------------------------------
  // Threshold compare
  // --------------------------------------------------------------------------
  // Strict compare so that 8'hFF high and 8'h00 low can never be crossed
  function automatic logic [1:0] check(
    input logic [`LQM_PARAM_W-1:0] value,
    input logic [`LQM_PARAM_W-1:0] low,
    input logic [`LQM_PARAM_W-1:0] high
  );
    check = {value > high, value < low};
  endfunction : check

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  lqm_pkg::lqm_state_t    st;
  lqm_pkg::lqm_state_t    next_st;
  logic                   active;
  logic                   wr_hit;
  logic                   rd_hit;
  logic [`LQM_WARN_W-1:0] viol;
  logic [`LQM_WARN_W-1:0] new_v;
  logic                   restart_req;

  assign active = st.ctrl[`LQM_CTRL_W-1] & LINK_100_OK;
  assign wr_hit = WR && (ADDR == `LQM_ADDR);
  assign rd_hit = RD && (ADDR == `LQM_ADDR);

  always_comb begin
    next_st         = st;
    next_st.rdata   = '0;
    next_st.restart = 1'b0;
    next_st.drop    = 1'b0;
    next_st.irq     = 1'b0;
    restart_req     = 1'b0;
    for (int i = 0; i < `LQM_NUM_PARAM; i++) begin
      viol[2*i +: 2] = active ?
        check(PARAM[i], THRESH.low[i], THRESH.high[i]) : 2'b00;
    end
    new_v = viol & ~st.warn;
    // Control bit i (10..14) steers restart for parameter i
    for (int i = 0; i < `LQM_NUM_PARAM; i++) begin
      if (st.ctrl[i] && (|new_v[2*i +: 2])) begin
        restart_req = 1'b1;
      end
    end
    next_st.restart = restart_req;
    next_st.drop    = restart_req & ~SIGNAL_DETECT_OPTION;
    if (wr_hit) begin
      next_st.ctrl = WDATA[`LQM_DATA_W-1:`LQM_CTRL_LSB];
    end
    // Current violations win over the read clear
    if (rd_hit) begin
      next_st.rdata    = {st.ctrl, st.warn};
      next_st.warn     = viol;
      next_st.disarmed = 1'b0;
    end else begin
      next_st.warn = st.warn | viol;
    end
    if ((|new_v) && INT_ENABLE && (!st.disarmed || rd_hit)) begin
      next_st.irq      = 1'b1;
      next_st.disarmed = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA       = st.rdata;
  assign DSP_RESTART = st.restart;
  assign LINK_DROP   = st.drop;
  assign IRQ_EVENT   = st.irq;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  sequence s_fire;
    IRQ_EVENT;
  endsequence

  sequence s_no_read;
    !rd_hit [*2];
  endsequence

  a_read_data: assert property (
    rd_hit |=> RDATA == $past({st.ctrl, st.warn}))
    else $error("read data does not match register");

  a_unmapped_zero: assert property (
    (RD && !rd_hit) |=> RDATA == '0)
    else $error("unmapped read not zero");

  a_read_clears: assert property (
    (rd_hit && viol == '0) |=> st.warn == '0)
    else $error("read did not clear warnings");

  a_warn_sticky: assert property (
    !rd_hit |=> (st.warn & $past(st.warn)) == $past(st.warn))
    else $error("warning dropped without read");

  a_idle_no_warn: assert property (
    (!active && !rd_hit) |=> st.warn == $past(st.warn))
    else $error("warning raised while monitor inactive");

  a_fc_high: assert property (
    (active && PARAM[4] > THRESH.high[4]) |=> st.warn[9])
    else $error("freq control high warning missed");

  a_eq_low: assert property (
    (active && PARAM[0] < THRESH.low[0]) |=> st.warn[0])
    else $error("equalizer low warning missed");

  a_ctrl_write: assert property (
    wr_hit |=> st.ctrl == $past(WDATA[`LQM_DATA_W-1:`LQM_CTRL_LSB]))
    else $error("control write lost");

  a_restart_cause: assert property (
    DSP_RESTART |-> $past(|(new_v & {{2{st.ctrl[4]}}, {2{st.ctrl[3]}},
      {2{st.ctrl[2]}}, {2{st.ctrl[1]}}, {2{st.ctrl[0]}}})))
    else $error("restart without enabled violation");

  a_drop_pairs: assert property (
    LINK_DROP |-> DSP_RESTART && !$past(SIGNAL_DETECT_OPTION))
    else $error("link drop without restart or with option set");

  a_irq_enable: assert property (
    IRQ_EVENT |-> $past(INT_ENABLE) && $past(|new_v))
    else $error("interrupt without enabled violation");

  a_irq_rearm: assert property (
    s_fire ##1 s_no_read |-> !IRQ_EVENT)
    else $error("interrupt fired again before read");

  // --------------------------------------------------------------------------
  // Warning bits per parameter
  // --------------------------------------------------------------------------
  a_fc_low: assert property (
    (active && PARAM[4] < THRESH.low[4]) |=> st.warn[8])
    else $error("freq control low warning missed");

  a_fo_high: assert property (
    (active && PARAM[3] > THRESH.high[3]) |=> st.warn[7])
    else $error("freq offset high warning missed");

  a_fo_low: assert property (
    (active && PARAM[3] < THRESH.low[3]) |=> st.warn[6])
    else $error("freq offset low warning missed");

  a_blw_high: assert property (
    (active && PARAM[2] > THRESH.high[2]) |=> st.warn[5])
    else $error("baseline wander high warning missed");

  a_blw_low: assert property (
    (active && PARAM[2] < THRESH.low[2]) |=> st.warn[4])
    else $error("baseline wander low warning missed");

  a_gc_high: assert property (
    (active && PARAM[1] > THRESH.high[1]) |=> st.warn[3])
    else $error("gain control high warning missed");

  a_gc_low: assert property (
    (active && PARAM[1] < THRESH.low[1]) |=> st.warn[2])
    else $error("gain control low warning missed");

  a_eq_high: assert property (
    (active && PARAM[0] > THRESH.high[0]) |=> st.warn[1])
    else $error("equalizer high warning missed");

  a_warn_inactive: assert property (
    !active |-> viol == '0)
    else $error("violation seen while monitor inactive");

  a_warn_set: assert property (
    (|viol) |=> (st.warn & $past(viol)) == $past(viol))
    else $error("violation did not set its warning");

  a_warn_exact: assert property (
    !rd_hit |=> st.warn == ($past(st.warn) | $past(viol)))
    else $error("warning bits changed without cause");

  a_read_reload: assert property (
    rd_hit |=> st.warn == $past(viol))
    else $error("read did not reload current violations");

  // --------------------------------------------------------------------------
  // Restart and link drop
  // --------------------------------------------------------------------------
  a_restart_fc: assert property (
    (st.ctrl[4] && (|new_v[9:8])) |=> DSP_RESTART)
    else $error("freq control restart missed");

  a_restart_fo: assert property (
    (st.ctrl[3] && (|new_v[7:6])) |=> DSP_RESTART)
    else $error("freq offset restart missed");

  a_restart_blw: assert property (
    (st.ctrl[2] && (|new_v[5:4])) |=> DSP_RESTART)
    else $error("baseline wander restart missed");

  a_restart_gc: assert property (
    (st.ctrl[1] && (|new_v[3:2])) |=> DSP_RESTART)
    else $error("gain control restart missed");

  a_restart_eq: assert property (
    (st.ctrl[0] && (|new_v[1:0])) |=> DSP_RESTART)
    else $error("equalizer restart missed");

  a_restart_quiet: assert property (
    !(|new_v) |=> !DSP_RESTART)
    else $error("restart without new violation");

  a_drop_follow: assert property (
    (restart_req && !SIGNAL_DETECT_OPTION) |=> LINK_DROP)
    else $error("link drop missed");

  a_drop_option: assert property (
    SIGNAL_DETECT_OPTION |=> !LINK_DROP)
    else $error("link drop with option set");

  a_drop_quiet: assert property (
    !restart_req |=> !LINK_DROP)
    else $error("link drop without restart");

  // --------------------------------------------------------------------------
  // Interrupt arming
  // --------------------------------------------------------------------------
  sequence s_read_new;
    rd_hit && (|new_v) && INT_ENABLE;
  endsequence

  a_irq_fire: assert property (
    ((|new_v) && INT_ENABLE && !st.disarmed) |=> IRQ_EVENT)
    else $error("armed interrupt missed");

  a_irq_masked: assert property (
    !INT_ENABLE |=> !IRQ_EVENT)
    else $error("interrupt while disabled");

  a_irq_quiet: assert property (
    !(|new_v) |=> !IRQ_EVENT)
    else $error("interrupt without new violation");

  a_read_fire: assert property (
    s_read_new |=> IRQ_EVENT)
    else $error("read with new violation did not fire");

  a_read_rearm: assert property (
    rd_hit |=> !st.disarmed || IRQ_EVENT)
    else $error("read did not re-arm interrupt");

  a_disarm_hold: assert property (
    (st.disarmed && !rd_hit) |=> st.disarmed)
    else $error("interrupt re-armed without read");

  // --------------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------------
  a_rdata_idle: assert property (
    !RD |=> RDATA == '0)
    else $error("read data not zero outside read");

  a_rdata_ctrl: assert property (
    rd_hit |=> RDATA[15:10] == $past(st.ctrl))
    else $error("read data control field wrong");

  a_rdata_warn: assert property (
    rd_hit |=> RDATA[9:0] == $past(st.warn))
    else $error("read data warning field wrong");

  a_ctrl_hold: assert property (
    !wr_hit |=> st.ctrl == $past(st.ctrl))
    else $error("control changed without write");

  a_unmapped_write: assert property (
    (WR && !wr_hit) |=> st.ctrl == $past(st.ctrl))
    else $error("unmapped write changed control");

endmodule : link_quality_monitor_ctrl

// file: lqm_cfg.svh
`ifndef LQM_CFG_SVH
`define LQM_CFG_SVH
//
// Overview of operation
// - Bit 15 enables monitoring, active only with a valid 100 Mb link.
// - A threshold violation raises the interrupt when its enable is set.
// - Reading the register clears warnings not still violated and re-arms the interrupt.
// - Bit 14 set: frequency control violation resets DSP, restarts adaption.
// - Bit 13 set: frequency offset violation resets DSP, restarts adaption.
// - Bit 12 set: baseline wander violation resets DSP, restarts adaption.
// - Bit 11 set: gain control violation resets DSP, restarts adaption.
// - Bit 10 set: equalizer coefficient violation resets DSP, restarts.
// - Enabled restart with signal detect option 0 also drops link status.
// - Bits 9/8 flag frequency control high/low; clear on read.
// - Bits 7/6 flag frequency offset high/low; clear on read.
// - Bits 5/4 flag baseline wander high/low; clear on read.
// - Bits 3/2 flag gain control high/low; clear on read.
// - Bits 1/0 flag equalizer coefficient high/low; clear on read.

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define LQM_ADDR_W      5
`define LQM_ADDR        5'h1D
`define LQM_DATA_W      16
`define LQM_RESET       16'h0000
`define MONITOR_ENABLE_BIT  15
`define LQM_CTRL_LSB    10
`define LQM_CTRL_W      6
`define LQM_WARN_W      10
`define LQM_NUM_PARAM   5
`define LQM_PARAM_W     8

`endif

// file: lqm_pkg.sv
`include "lqm_cfg.svh"

package lqm_pkg;

  typedef logic [`LQM_NUM_PARAM-1:0][`LQM_PARAM_W-1:0] lq_vec_t;

  // Index 0 equalizer, 1 gain, 2 baseline wander, 3 freq offset, 4 freq ctrl
  typedef struct packed {
    lq_vec_t low;
    lq_vec_t high;
  } lq_thr_t;

  typedef struct packed {
    logic [`LQM_CTRL_W-1:0] ctrl;
    logic [`LQM_WARN_W-1:0] warn;
    logic                   disarmed;
    logic [`LQM_DATA_W-1:0] rdata;
    logic                   restart;
    logic                   drop;
    logic                   irq;
  } lqm_state_t;

endpackage : lqm_pkg

// file: test_link_quality_monitor_ctrl.sv
`timescale 1ns/1ps
`include "lqm_cfg.svh"

module test_link_quality_monitor_ctrl;
  localparam logic [4:0] A = 5'h1D;
  logic              clock, srst, wr, rd, link, opt, ien;
  logic [4:0]        addr;
  logic [15:0]       wdata, rdata, r, ctl, bv;
  logic              restart, drop, irq;
  lqm_pkg::lq_vec_t  param;
  lqm_pkg::lq_thr_t  thresh;
  int                miscompares, compares;
  typedef struct {int idx; bit hi; bit opt;} row_t;
  row_t rows [10] = '{'{0,0,0},'{0,1,1},'{1,0,1},'{1,1,0},'{2,0,0},
    '{2,1,1},'{3,0,1},'{3,1,0},'{4,0,0},'{4,1,1}};
  wire [15:0] pl = {13'h0000, restart, drop, irq};

  link_quality_monitor_ctrl link_quality_monitor_ctrl_i (
    .CLOCK(clock), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .LINK_100_OK(link),
    .SIGNAL_DETECT_OPTION(opt), .INT_ENABLE(ien), .PARAM(param),
    .THRESH(thresh), .DSP_RESTART(restart), .LINK_DROP(drop),
    .IRQ_EVENT(irq));

  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end

  // --------------------------------------------------------------
  // Bus cycles and checks
  // --------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr_reg(input logic [15:0] d);
    addr <= A;
    wdata <= d;
    wr <= 1;
    @(posedge clock);
    wr <= 0;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1;
    @(posedge clock);
    rd <= 0;
    #1 d = rdata;
    @(posedge clock);
  endtask : rd_reg
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  initial begin
    {wr, rd, opt, addr, wdata} = '0;
    {srst, link, ien} = 3'h7;
    param = {5{8'h80}};
    thresh = {{5{8'h10}}, {5{8'hF0}}};
    repeat (10) @(posedge clock);
    srst <= 0;
    @(posedge clock);
    rd_reg(A, r); cmp(r, 16'h0000);
    wr_reg(16'hFFFF); rd_reg(A, r); cmp(r, 16'hFC00);
    rd_reg(5'h02, r); cmp(r, 16'h0000);
    foreach (rows[k]) begin
      ctl = 16'h8000 | (16'h0400 << rows[k].idx);
      bv = 16'h0001 << (2 * rows[k].idx + rows[k].hi);
      wr_reg(ctl);
      opt <= rows[k].opt;
      param[rows[k].idx] <= rows[k].hi ? 8'hFF : 8'h00;
      @(posedge clock);
      #1 cmp(pl, {13'h0000, 1'b1, ~rows[k].opt, 1'b1});
      @(posedge clock);
      param <= {5{8'h80}};
      #1 cmp(pl, 16'h0000);
      @(posedge clock);
      rd_reg(A, r); cmp(r, ctl | bv);
      rd_reg(A, r); cmp(r, ctl);
    end
    // Second violation before a read gives no interrupt
    wr_reg(16'h8000);
    param[0] <= 8'hFF;
    @(posedge clock);
    #1 cmp(pl, 16'h0001);
    @(posedge clock);
    param[1] <= 8'hFF;
    @(posedge clock);
    #1 cmp(pl, 16'h0000);
    @(posedge clock);
    param <= {5{8'h80}};
    @(posedge clock);
    rd_reg(A, r); cmp(r, 16'h800A);
    param[2] <= 8'hFF;
    @(posedge clock);
    #1 cmp(pl, 16'h0001);
    @(posedge clock);
    // Link down, maximum threshold and masked interrupt
    link <= 0;
    thresh.high[0] <= 8'hFF;
    param <= {8'h80, 8'h80, 8'h80, 8'hFF, 8'hFF};
    repeat (2) @(posedge clock);
    link <= 1;
    ien <= 0;
    param[1] <= 8'h80;
    param[3] <= 8'hFF;
    @(posedge clock);
    #1 cmp(pl, 16'h0000);
    @(posedge clock);
    rd_reg(A, r); cmp(r, 16'h80A0);
    end_sim();
  end
endmodule : test_link_quality_monitor_ctrl
